// ---- amm_pkg.sv ----
// Package for the alarm, mask and output-silence control block.
// Assumes an 8-bit register port carrying the documented 16-bit offsets.
package amm_pkg;

  // Register offsets, as seen on the device register port.
  localparam logic [15:0] ADDR_ALARM_STATUS     = 16'h0430;
  localparam logic [15:0] ADDR_ALARM_MASK       = 16'h0431;
  localparam logic [15:0] ADDR_SILENCE_SUPPRESS = 16'h0432;
  localparam logic [15:0] ADDR_RECOVERY_SELECT  = 16'h0433;
  localparam logic [15:0] ADDR_FUSE_STATE       = 16'h0600;

  // Field positions shared by the alarm status, mask, suppress and recovery registers, and the done bit of the fuse state register.
  localparam int BIT_LINK_LOST    = 7;
  localparam int BIT_LINK_TIMEOUT = 6;
  localparam int BIT_CRC_ERROR    = 5;
  localparam int BIT_SYSREF       = 0;
  localparam int BIT_FUSE_DONE    = 0;

  // Reset values of the writable registers.
  localparam logic [7:0] RST_ALARM_MASK       = 8'h00;
  localparam logic [7:0] RST_SILENCE_SUPPRESS = 8'h21;
  localparam logic [7:0] RST_RECOVERY_SELECT  = 8'ha0;

  // Alarm status bits that hold a flag; all others read as zero.
  localparam logic [7:0] ALARM_IMPL_BITS = 8'he1;

  // The fuse auto-load ends in fewer than this many device clock cycles.
  localparam int FUSE_LOAD_LIMIT_CYCLES = 523000;
  localparam int FUSE_LOAD_CYCLES_DEF   = FUSE_LOAD_LIMIT_CYCLES - 1;
  localparam int FUSE_CNT_W             = 20;

  // Period of the link-down timer tick, in device clock cycles.
  localparam int LINK_TICK_CYCLES_DEF = 256;
  localparam int LINK_TIMER_W         = 8;

  // Fuse controller states; a single bit is its own Gray code.
  typedef enum logic [0:0] {
    FUSE_LOADING = 1'b0,
    FUSE_IDLE    = 1'b1
  } amm_fuse_state_type;

endpackage

// ---- amm_fuse_if.sv ----
// Interface carrying the fuse controller status to the register logic.
// Assumes both ends run on the device clock.
`timescale 1ns/10ps
interface amm_fuse_if;
  logic busy;
  logic done;

  // The loader drives the status, the register logic reads it.
  modport loader (output busy, output done);
  modport user   (input busy, input done);
endinterface

// ---- amm_sticky_flag.sv ----
// One write-one-to-clear alarm flag.
// Assumes set and clear come from logic on the same clock.
`timescale 1ns/10ps
module amm_sticky_flag (
  // Clock and reset.
  input  wire logic i_clk_sys,
  input  wire logic i_srst,
  // Event and software clear.
  input  wire logic i_set,
  input  wire logic i_clr,
  // Flag state.
  output logic      o_flag
);

  logic flag_ff;

  // Set wins over clear so an event in the clearing cycle is kept.
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      flag_ff <= 1'b0;
    end else if (i_set) begin
      flag_ff <= 1'b1;
    end else if (i_clr) begin
      flag_ff <= 1'b0;
    end
  end

  assign o_flag = flag_ff;

  AST_SET_WINS: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    i_set |=> o_flag) else $error("alarm flag lost an event");
  AST_CLR_ONLY: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (o_flag && i_clr && !i_set) |=> !o_flag) else $error("alarm flag not cleared");

endmodule

// ---- amm_fuse_loader.sv ----
// Fuse auto-load sequencer: busy from reset until the load time has run out.
// Assumes the fuse array itself is read elsewhere during the busy window.
`timescale 1ns/10ps
module amm_fuse_loader
  import amm_pkg::*;
#(
  parameter int LOAD_CYCLES = FUSE_LOAD_CYCLES_DEF
) (
  // Clock and reset.
  input  wire logic i_clk_sys,
  input  wire logic i_srst,
  // Status towards the register logic.
  amm_fuse_if.loader fuse
);

  localparam int LOAD_LIMIT = FUSE_LOAD_LIMIT_CYCLES;
  localparam logic [FUSE_CNT_W-1:0] LAST_CNT = FUSE_CNT_W'(LOAD_CYCLES - 1);

  amm_fuse_state_type         state_ff;
  logic [FUSE_CNT_W-1:0]      cnt_ff;

  // Every reset restarts the load, so software must wait again afterwards.
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      state_ff <= FUSE_LOADING;
    end else begin
      unique case (state_ff)
        FUSE_LOADING: begin
          if (cnt_ff == LAST_CNT) begin
            state_ff <= FUSE_IDLE;
          end
        end
        FUSE_IDLE: begin
          state_ff <= FUSE_IDLE;
        end
      endcase
    end
  end

  // Load cycle counter; it stops on the last count so it stands still while idle.
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      cnt_ff <= '0;
    end else if (state_ff == FUSE_LOADING && cnt_ff != LAST_CNT) begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  assign fuse.busy = (state_ff == FUSE_LOADING);
  assign fuse.done = (state_ff == FUSE_IDLE);

  AST_FUSE_BOUND: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    fuse.busy |-> (int'(cnt_ff) < LOAD_LIMIT)) else $error("fuse load overran");
  AST_FUSE_DONE: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    fuse.done |-> (!fuse.busy && $stable(cnt_ff))) else $error("fuse done while busy");

endmodule

// ---- amm_top.sv ----
// Alarm aggregation, alarm masking and output-silence control.
// Assumes link, lane and SYSREF status come from logic on i_clk_sys.
//
// Functional notes
// - Link-lost mask bit 7 keeps that alarm off the alarm output.
// - Link-timeout mask bit 6 keeps that alarm off the alarm output.
// - CRC mask bit 5 keeps the CRC alarm off the alarm output.
// - SYSREF mask bit 0 keeps the SYSREF alarm off the alarm output.
// - Pending CRC alarm silences outputs unless suppress bit 5 set; resets to 1.
// - Pending SYSREF alarm silences outputs unless suppress bit 0 set; resets to 1.
// - Link-lost recovery 0 waits for alarm clear; 1 unmutes on link recovery.
// - CRC recovery bit 5 only matters while CRC suppress bit is 0.
// - CRC recovery 0 waits for alarm clear; 1 unmutes when fault ends.
// - Fuse done reads 1 only when the fuse loader is idle.
// - Fuse auto-load completes in fewer than 523,000 clock cycles.
// - Link-up falling while enabled sets link-lost alarm; write 1 clears.
// - Link down too long while enabled sets link-timeout alarm; write 1 clears.
// - CRC fault on enabled lane in 64b/66b sets CRC alarm; write 1 clears.
// - Misaligned SYSREF edge (link check only while enabled) sets the SYSREF alarm; write 1 clears.
`timescale 1ns/10ps
module amm_top
  import amm_pkg::*;
#(
  parameter int LANES            = 16,
  parameter int FUSE_LOAD_CYCLES = FUSE_LOAD_CYCLES_DEF,
  parameter int LINK_TICK_CYCLES = LINK_TICK_CYCLES_DEF
) (
  // Clock and reset.
  input  wire logic                    i_clk_sys,
  input  wire logic                    i_srst,
  // Register port.
  input  wire logic [15:0]             i_reg_addr,
  input  wire logic                    i_reg_wr_en,
  input  wire logic [7:0]              i_reg_wdata,
  input  wire logic                    i_reg_rd_en,
  output logic      [7:0]              o_reg_rdata,
  output logic                         o_reg_rdata_valid,
  // Link status.
  input  wire logic                    i_link_up,
  input  wire logic                    i_link_interface_enable,
  input  wire logic [LINK_TIMER_W-1:0] i_link_down_timer,
  input  wire logic                    i_mode_64b66b,
  input  wire logic [LANES-1:0]        i_lane_enable,
  input  wire logic [LANES-1:0]        i_crc_fault,
  // SYSREF alignment checks.
  input  wire logic                    i_sysref_misalign_clk,
  input  wire logic                    i_sysref_misalign_link,
  // Block outputs.
  output logic                         o_alarm,
  output logic                         o_mute,
  output logic                         o_fuse_load_done
);

  localparam int TICK_W = (LINK_TICK_CYCLES > 1) ? $clog2(LINK_TICK_CYCLES) : 1;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(LINK_TICK_CYCLES - 1);
  localparam int DOWN_W = LINK_TIMER_W + 1;

  // Software-written control registers.
  logic [7:0]        alarm_output_mask_ff;
  logic [7:0]        output_silence_suppress_ff;
  logic [7:0]        silence_recovery_select_ff;
  // Read port.
  logic [7:0]        rdata_ff;
  logic              rvalid_ff;
  logic [7:0]        nxt_rdata;
  // Event detection.
  logic              link_up_d_ff;
  logic [TICK_W-1:0] tick_cnt_ff;
  logic [DOWN_W-1:0] down_cnt_ff;
  logic              link_tick;
  logic              link_lost_evt;
  logic              link_timeout_evt;
  logic              crc_fault_now;
  logic              sysref_evt;
  logic              link_down_ff;
  // Alarm flags and their set and clear strobes.
  logic [7:0]        alarm_set;
  logic [7:0]        alarm_clr;
  logic [7:0]        system_alarm_status;
  logic              alarm_pend;
  // Silence terms.
  logic              link_mute;
  logic              crc_mute;
  logic              sysref_mute;
  logic              alarm_ff;
  logic              mute_ff;

  amm_fuse_if fuse ();

  // Fuse loader, started by every reset.
  amm_fuse_loader #(
    .LOAD_CYCLES (FUSE_LOAD_CYCLES)
  ) u_fuse_loader (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst),
    .fuse      (fuse)
  );

  // Writable registers keep their reserved bits, which read back as written.
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      alarm_output_mask_ff       <= RST_ALARM_MASK;
      output_silence_suppress_ff <= RST_SILENCE_SUPPRESS;
      silence_recovery_select_ff <= RST_RECOVERY_SELECT;
    end else if (i_reg_wr_en) begin
      if (i_reg_addr == ADDR_ALARM_MASK) begin
        alarm_output_mask_ff <= i_reg_wdata;
      end
      if (i_reg_addr == ADDR_SILENCE_SUPPRESS) begin
        output_silence_suppress_ff <= i_reg_wdata;
      end
      if (i_reg_addr == ADDR_RECOVERY_SELECT) begin
        silence_recovery_select_ff <= i_reg_wdata;
      end
    end
  end

  // Read mux; unmapped offsets and unused status bits read as zero.
  always_comb begin
    nxt_rdata = 8'h00;
    unique case (i_reg_addr)
      ADDR_ALARM_STATUS:     nxt_rdata = system_alarm_status;
      ADDR_ALARM_MASK:       nxt_rdata = alarm_output_mask_ff;
      ADDR_SILENCE_SUPPRESS: nxt_rdata = output_silence_suppress_ff;
      ADDR_RECOVERY_SELECT:  nxt_rdata = silence_recovery_select_ff;
      ADDR_FUSE_STATE:       nxt_rdata[BIT_FUSE_DONE] = fuse.done;
      default:               nxt_rdata = 8'h00;
    endcase
  end

  // Read data is registered and valid one cycle after the strobe.
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      rdata_ff  <= 8'h00;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= i_reg_rd_en;
      if (i_reg_rd_en) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  // Previous link state, used to catch the falling edge of link-up.
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      link_up_d_ff <= 1'b0;
    end else begin
      link_up_d_ff <= i_link_up;
    end
  end

  assign link_lost_evt = link_up_d_ff & ~i_link_up & i_link_interface_enable;

  // Timer tick divider; a coarse tick keeps the down counter narrow.
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      tick_cnt_ff <= '0;
    end else if (tick_cnt_ff == TICK_LAST) begin
      tick_cnt_ff <= '0;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 1'b1;
    end
  end

  assign link_tick = (tick_cnt_ff == TICK_LAST);

  // Down-time counter in ticks; it passes the limit once and then saturates.
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      down_cnt_ff <= '0;
    end else if (i_link_up || !i_link_interface_enable) begin
      down_cnt_ff <= '0;
    end else if (link_tick && !(&down_cnt_ff)) begin
      down_cnt_ff <= down_cnt_ff + 1'b1;
    end
  end

  assign link_timeout_evt = link_tick && !i_link_up && i_link_interface_enable
                            && (down_cnt_ff == {1'b0, i_link_down_timer});

  // Faults on disabled lanes and outside 64b/66b are not alarms.
  assign crc_fault_now = i_mode_64b66b & (|(i_crc_fault & i_lane_enable));
  assign sysref_evt    = i_sysref_misalign_clk
                         | (i_sysref_misalign_link & i_link_interface_enable);

  // Set and write-one-to-clear strobes for the status flags.
  always_comb begin
    alarm_set                   = 8'h00;
    alarm_set[BIT_LINK_LOST]    = link_lost_evt;
    alarm_set[BIT_LINK_TIMEOUT] = link_timeout_evt;
    alarm_set[BIT_CRC_ERROR]    = crc_fault_now;
    alarm_set[BIT_SYSREF]       = sysref_evt;
    alarm_clr = (i_reg_wr_en && i_reg_addr == ADDR_ALARM_STATUS)
                ? (i_reg_wdata & ALARM_IMPL_BITS) : 8'h00;
  end

  // One sticky flag per implemented status bit; the rest stay zero.
  for (genvar i = 0; i < 8; i++) begin : g_alarm
    if (ALARM_IMPL_BITS[i]) begin : g_flag
      amm_sticky_flag u_flag (
        .i_clk_sys (i_clk_sys),
        .i_srst    (i_srst),
        .i_set     (alarm_set[i]),
        .i_clr     (alarm_clr[i]),
        .o_flag    (system_alarm_status[i])
      );
    end else begin : g_zero
      assign system_alarm_status[i] = 1'b0;
    end
  end

  // Link loss remembered until link-up returns, for automatic recovery.
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      link_down_ff <= 1'b0;
    end else if (link_lost_evt) begin
      link_down_ff <= 1'b1;
    end else if (i_link_up) begin
      link_down_ff <= 1'b0;
    end
  end

  // Link loss has no suppress bit, so it always silences until recovery.
  assign link_mute = system_alarm_status[BIT_LINK_LOST]
                     & (silence_recovery_select_ff[BIT_LINK_LOST] ? link_down_ff : 1'b1);

  // Recovery select is consulted only when the CRC alarm may silence at all.
  assign crc_mute = system_alarm_status[BIT_CRC_ERROR]
                    & ~output_silence_suppress_ff[BIT_CRC_ERROR]
                    & (silence_recovery_select_ff[BIT_CRC_ERROR] ? crc_fault_now : 1'b1);

  assign sysref_mute = system_alarm_status[BIT_SYSREF]
                       & ~output_silence_suppress_ff[BIT_SYSREF];

  // Any set alarm whose mask bit is clear drives the alarm output.
  assign alarm_pend = |(system_alarm_status & ~alarm_output_mask_ff & ALARM_IMPL_BITS);

  // Outputs are registered so they cannot glitch on register writes.
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      alarm_ff <= 1'b0;
      mute_ff  <= 1'b0;
    end else begin
      alarm_ff <= alarm_pend;
      mute_ff  <= link_mute | crc_mute | sysref_mute;
    end
  end

  assign o_alarm           = alarm_ff;
  assign o_mute            = mute_ff;
  assign o_reg_rdata       = rdata_ff;
  assign o_reg_rdata_valid = rvalid_ff;
  assign o_fuse_load_done  = fuse.done;

  // Checks on the alarm, masking and silence paths.
  AST_ALARM_OUT: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    ##1 (o_alarm == $past(alarm_pend))) else $error("alarm output wrong");
  AST_MASK_LINK: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (system_alarm_status == 8'h80 && alarm_output_mask_ff[7]) |=> !o_alarm)
    else $error("masked link-lost alarm reached output");
  AST_MASK_TIMEOUT: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (system_alarm_status == 8'h40) |=> (o_alarm != $past(alarm_output_mask_ff[6])))
    else $error("link-timeout mask ignored");
  AST_MASK_CRC: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (system_alarm_status == 8'h20 && alarm_output_mask_ff[5]) |=> !o_alarm)
    else $error("masked CRC alarm reached output");
  AST_MASK_SYSREF: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (system_alarm_status == 8'h01) |=> (o_alarm != $past(alarm_output_mask_ff[0])))
    else $error("SYSREF mask ignored");
  AST_CRC_MUTE: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (system_alarm_status[5] && !output_silence_suppress_ff[5]
     && !silence_recovery_select_ff[5]) |=> o_mute)
    else $error("CRC alarm did not silence outputs");
  AST_CRC_SUPPRESS: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    output_silence_suppress_ff[5] |-> !crc_mute)
    else $error("suppressed CRC alarm silenced outputs");
  AST_SYSREF_MUTE: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (system_alarm_status[0] && !output_silence_suppress_ff[0]) |=> o_mute)
    else $error("SYSREF alarm did not silence outputs");
  AST_LINK_LOST_SET: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    ($fell(i_link_up) && i_link_interface_enable) |=> system_alarm_status[7])
    else $error("link loss not flagged");
  AST_LINK_AUTO: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (silence_recovery_select_ff[7] && i_link_up && !link_lost_evt
     && !(i_reg_wr_en && i_reg_addr == ADDR_RECOVERY_SELECT)) |=> !link_mute)
    else $error("link silence held after recovery");
  AST_TIMEOUT_SET: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    link_timeout_evt |=> system_alarm_status[6])
    else $error("link timeout not flagged");
  AST_CRC_SET: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (i_mode_64b66b && |(i_crc_fault & i_lane_enable)) |=> system_alarm_status[BIT_CRC_ERROR])
    else $error("CRC fault not flagged");
  AST_SYSREF_SET: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (i_sysref_misalign_clk || (i_sysref_misalign_link && i_link_interface_enable))
    |=> system_alarm_status[BIT_SYSREF])
    else $error("SYSREF misalignment not flagged");
  AST_CRC_AUTO: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (silence_recovery_select_ff[5] && !crc_fault_now) |-> !crc_mute)
    else $error("CRC silence held after fault ended");

endmodule

// ---- amm_top_tb_top.sv ----
// Self-checking bench for the alarm, mask and output-silence block.
// Assumes amm_pkg and the design files are compiled first.
`timescale 1ns/10ps
module amm_top_tb_top
  import amm_pkg::*;
;
  localparam int FL   = 20;
  localparam int TICK = 4;

  logic        i_clk_sys, i_srst, i_reg_wr_en, i_reg_rd_en, o_reg_rdata_valid;
  logic [15:0] i_reg_addr;
  logic [7:0]  i_reg_wdata, o_reg_rdata, i_link_down_timer, v;
  logic        i_link_up, i_link_interface_enable, i_mode_64b66b;
  logic [15:0] i_lane_enable, i_crc_fault;
  logic        i_sysref_misalign_clk, i_sysref_misalign_link;
  logic        o_alarm, o_mute, o_fuse_load_done;
  int          failures, tests_run, seed, n;
  bit          chk_on, chk_alm;
  // Reference model state, all updated at the rising edge.
  logic [7:0]  m_flags, m_mask, m_sup, m_rec, rq[$];
  logic        m_alarm, m_mute, m_valid, m_done, m_down, m_prev_up, fault;
  logic [7:0]  set, clr;
  int          fcnt;
  logic [15:0] addr_tab [8] = '{16'h0430, 16'h0431, 16'h0432, 16'h0433,
                                16'h0600, 16'h0434, 16'h0430, 16'h0433};

  amm_top #(.LANES(16), .FUSE_LOAD_CYCLES(FL), .LINK_TICK_CYCLES(TICK)) i_amm_top (
    .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_reg_addr(i_reg_addr),
    .i_reg_wr_en(i_reg_wr_en), .i_reg_wdata(i_reg_wdata), .i_reg_rd_en(i_reg_rd_en),
    .o_reg_rdata(o_reg_rdata), .o_reg_rdata_valid(o_reg_rdata_valid),
    .i_link_up(i_link_up), .i_link_interface_enable(i_link_interface_enable),
    .i_link_down_timer(i_link_down_timer), .i_mode_64b66b(i_mode_64b66b),
    .i_lane_enable(i_lane_enable), .i_crc_fault(i_crc_fault),
    .i_sysref_misalign_clk(i_sysref_misalign_clk),
    .i_sysref_misalign_link(i_sysref_misalign_link),
    .o_alarm(o_alarm), .o_mute(o_mute), .o_fuse_load_done(o_fuse_load_done));

  // Free-running device clock.
  initial begin
    i_clk_sys = 1'b0;
    forever #2.5 i_clk_sys = ~i_clk_sys;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    if (failures == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  function automatic logic [7:0] rd_value(input logic [15:0] a);
    case (a)
      16'h0430: return m_flags & 8'he1;
      16'h0431: return m_mask;
      16'h0432: return m_sup;
      16'h0433: return m_rec;
      16'h0600: return {7'h00, m_done};
      default:  return 8'h00;
    endcase
  endfunction

  // Model reads inputs before this edge's bench updates land, like the design.
  always @(posedge i_clk_sys) begin
    if (i_srst) begin
      m_flags = 8'h00; m_mask = 8'h00; m_sup = 8'h21; m_rec = 8'ha0;
      m_alarm = 1'b0; m_mute = 1'b0; m_valid = 1'b0; m_down = 1'b0;
      m_prev_up = 1'b0; fcnt = 0; m_done = 1'b0;
      rq.delete();
    end else begin
      fault = |(i_crc_fault & i_lane_enable);
      m_alarm = |(m_flags & ~m_mask & 8'he1);
      m_mute = (m_flags[7] & (m_rec[7] ? m_down : 1'b1))
             | (m_flags[5] & ~m_sup[5] & (m_rec[5] ? (fault & i_mode_64b66b) : 1'b1))
             | (m_flags[0] & ~m_sup[0]);
      m_valid = i_reg_rd_en;
      if (i_reg_rd_en) rq.push_back(rd_value(i_reg_addr));
      set = {m_prev_up & ~i_link_up & i_link_interface_enable, 1'b0,
             fault & i_mode_64b66b, 4'h0,
             i_sysref_misalign_clk | (i_sysref_misalign_link & i_link_interface_enable)};
      clr = 8'h00;
      if (i_reg_wr_en) begin
        case (i_reg_addr)
          16'h0430: clr = i_reg_wdata & 8'he1;
          16'h0431: m_mask = i_reg_wdata;
          16'h0432: m_sup = i_reg_wdata;
          16'h0433: m_rec = i_reg_wdata;
          default: ;
        endcase
      end
      m_flags = (m_flags & ~clr) | set;
      if (set[7]) m_down = 1'b1;
      else if (i_link_up) m_down = 1'b0;
      m_prev_up = i_link_up;
      fcnt++;
      m_done = (fcnt >= FL);
    end
  end

  // Outputs are compared in mid-cycle, once the edge has settled; o_alarm only while chk_alm is set.
  always @(negedge i_clk_sys) begin
    if (chk_on) begin
      if (chk_alm) check(o_alarm, m_alarm);
      check(o_mute, m_mute);
      check(o_fuse_load_done, m_done);
      check(o_reg_rdata_valid, m_valid);
      if (m_valid) check(o_reg_rdata, rq.pop_front());
    end
  end

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_reg_addr <= a; i_reg_wdata <= d; i_reg_wr_en <= 1'b1;
    @(posedge i_clk_sys);
    i_reg_wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge i_clk_sys);
    i_reg_addr <= a; i_reg_rd_en <= 1'b1;
    @(posedge i_clk_sys);
    i_reg_rd_en <= 1'b0;
    @(negedge i_clk_sys);
    d = o_reg_rdata;
  endtask

  // Reset keeps the link up so no false link-lost edge appears at release.
  task automatic do_reset(input int cycles);
    @(posedge i_clk_sys);
    i_srst <= 1'b1; i_link_up <= 1'b1; i_link_interface_enable <= 1'b0;
    i_reg_wr_en <= 1'b0; i_reg_rd_en <= 1'b0;
    i_link_down_timer <= 8'hff;
    repeat (cycles) @(posedge i_clk_sys);
    i_srst <= 1'b0;
    rd(16'h0600, v);
    check(v, 8'h00);
    n = 0;
    while (o_fuse_load_done !== 1'b1 && n < FL + 4) begin
      @(negedge i_clk_sys);
      n++;
    end
    check(o_fuse_load_done, 1'b1);
  endtask

  // Watchdog sized well above the planned run of about 4100 cycles.
  initial begin
    #100000;
    failures++;
    results();
  end

  initial begin
    seed = 32'h4eb0;
    failures = 0; tests_run = 0; chk_on = 1'b0; chk_alm = 1'b1;
    i_srst = 1'b1; i_reg_addr = 16'h0000; i_reg_wr_en = 1'b0; i_reg_wdata = 8'h00;
    i_reg_rd_en = 1'b0; i_link_up = 1'b1; i_link_interface_enable = 1'b0;
    i_link_down_timer = 8'hff; i_mode_64b66b = 1'b1; i_lane_enable = 16'hffff;
    i_crc_fault = 16'h0000; i_sysref_misalign_clk = 1'b0; i_sysref_misalign_link = 1'b0;
    @(posedge i_clk_sys);
    chk_on = 1'b1;
    do_reset(20);
    rd(16'h0431, v); check(v, 8'h00);
    rd(16'h0432, v); check(v, 8'h21);
    rd(16'h0433, v); check(v, 8'ha0);
    // Faults on a non-64b/66b link or a disabled lane must not raise the CRC flag.
    wr(16'h0430, 8'hff);
    @(posedge i_clk_sys);
    i_mode_64b66b <= 1'b0; i_crc_fault <= 16'hffff;
    repeat (4) @(posedge i_clk_sys);
    i_mode_64b66b <= 1'b1; i_lane_enable <= 16'h00ff; i_crc_fault <= 16'hff00;
    rd(16'h0430, v); check(v & 8'h20, 8'h00);
    // Random traffic on all inputs but i_srst, i_mode_64b66b and i_link_down_timer, registers hit back to back and unmapped.
    for (int i = 0; i < 4000; i++) begin
      @(posedge i_clk_sys);
      i_link_up <= ({$random(seed)} % 4 != 0);
      if ({$random(seed)} % 64 == 0) i_link_interface_enable <= ~i_link_interface_enable;
      i_lane_enable <= 16'($random(seed));
      i_crc_fault <= ({$random(seed)} % 8 == 0) ? 16'($random(seed)) : 16'h0000;
      i_sysref_misalign_clk <= ({$random(seed)} % 32 == 0);
      i_sysref_misalign_link <= ({$random(seed)} % 32 == 0);
      i_reg_addr <= addr_tab[{$random(seed)} % 8];
      i_reg_wdata <= 8'($random(seed));
      i_reg_wr_en <= ({$random(seed)} % 4 == 0);
      i_reg_rd_en <= ({$random(seed)} % 3 == 0);
    end
    @(posedge i_clk_sys);
    i_reg_wr_en <= 1'b0; i_reg_rd_en <= 1'b0; i_link_up <= 1'b1;
    i_crc_fault <= 16'h0000; i_sysref_misalign_clk <= 1'b0; i_sysref_misalign_link <= 1'b0;
    // Link held down past a short timer; the model has no timer, so alarm checks pause.
    wr(16'h0431, 8'hbf);
    wr(16'h0430, 8'hff);
    chk_alm = 1'b0;
    @(posedge i_clk_sys);
    i_link_interface_enable <= 1'b1; i_link_down_timer <= 8'h02; i_link_up <= 1'b0;
    n = 0;
    while (o_alarm !== 1'b1 && n < 100) begin
      @(negedge i_clk_sys);
      n++;
    end
    check(8'(n >= 2 * TICK && n <= 4 * TICK + 4), 8'h01);
    @(posedge i_clk_sys);
    i_link_up <= 1'b1;
    wr(16'h0430, 8'h40);
    repeat (3) @(negedge i_clk_sys);
    check(o_alarm, 1'b0);
    chk_alm = 1'b1;
    // A second reset mid-run restores defaults and restarts the fuse load.
    do_reset(3);
    rd(16'h0432, v); check(v, 8'h21);
    repeat (4) @(posedge i_clk_sys);
    results();
  end
endmodule
